// *** afecp_defines.vh ***
`ifndef AFECP_DEFINES_VH
`define AFECP_DEFINES_VH
`define AFECP_TARGET_ADDR      7'h48
`define AFECP_OFS_STATUS       8'h00
`define AFECP_OFS_PROTECT      8'h01
`define AFECP_OFS_TIA          8'h10
`define AFECP_OFS_REF          8'h11
`define AFECP_OFS_MODE         8'h12
`define AFECP_RST_STATUS       8'h00
`define AFECP_RST_PROTECT      8'h01
`define AFECP_RST_TIA          8'h1C
`define AFECP_RST_REF          8'h00
`define AFECP_RST_MODE         8'h00
`define AFECP_PROTECT_BIT      0
`define AFECP_READY_BIT        0
`define AFECP_MASK_PROTECT     8'h01
`define AFECP_MASK_TIA         8'h1F
`define AFECP_MASK_REF         8'hFF
`define AFECP_MASK_MODE        8'h87
`define AFECP_CLK_HZ           25000000
`define AFECP_SCL_MAX_HZ       100000
`define AFECP_TIMEOUT_US       25000
`define AFECP_TIMEOUT_CYC      ((`AFECP_CLK_HZ / 1000000) * `AFECP_TIMEOUT_US)
`define AFECP_READY_US         10
`define AFECP_READY_CYC        ((`AFECP_CLK_HZ / 1000000) * `AFECP_READY_US)
`endif

// *** afecp_sync.v ***
module afecp_sync #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule // afecp_sync

// *** afecp_timer.v ***
module afecp_timer #(
  parameter LIMIT = 1000,
  parameter WIDTH = 32
) (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_run,
  output reg  o_expired
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= {WIDTH{1'b0}};
      o_expired <= 1'b0;
    end else if (!i_run) begin
      count_reg <= {WIDTH{1'b0}};
      o_expired <= 1'b0;
    end else if (count_reg >= LIMIT[WIDTH-1:0] - 1'b1) begin
      o_expired <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end
endmodule // afecp_timer

// *** afecp_port.v ***
// Overview of operation
// - bus runs at standard mode, 100 kHz
// - fixed target address 1001000
// - drive low for zero, release for one
// - ack matching address, nack otherwise
// - write: pointer then data, each acked
// - read shifts out pointed register byte
// - scl low past timeout resets interface
// - own sda hold past timeout resets
// - protect bit locks transimpedance and reference
// - status bit zero until ready
// - transimpedance gain and load fields
// - reference bit 7 selects source
// - reference bits 6:5 internal zero
// - reference bit 4 bias polarity
// - reference bits 3:0 bias magnitude
// - mode register short switch and mode
// - deselected device ignores bus traffic
`include "afecp_defines.vh"
module afecp_port #(
  parameter TIMEOUT_CYC = `AFECP_TIMEOUT_CYC,
  parameter READY_CYC   = `AFECP_READY_CYC
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda,
  output wire       o_sda_oe_n,
  input  wire       i_module_select_n,
  output wire [2:0] o_feedback_resistor_sel,
  output wire [1:0] o_load_resistor_sel,
  output wire       o_ref_source_ext,
  output wire [1:0] o_internal_zero_sel,
  output wire       o_bias_negative,
  output wire [3:0] o_bias_sel,
  output wire       o_shorting_switch_en,
  output wire [2:0] o_operating_mode_sel,
  output wire       o_ready
);
  // serial interface states
  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_AACK  = 3'd2;
  localparam ST_WRX   = 3'd3;
  localparam ST_WACK  = 3'd4;
  localparam ST_TX    = 3'd5;
  localparam ST_RACK  = 3'd6;

  wire [2:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       sel_n_s;

  afecp_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h7)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_scl, i_sda, i_module_select_n}),
    .o_sync  (pins_s)
  );
  assign scl_s   = pins_s[2];
  assign sda_s   = pins_s[1];
  assign sel_n_s = pins_s[0];

  reg        scl_d_reg;
  reg        sda_d_reg;
  reg [2:0]  state_reg;
  reg [3:0]  bit_reg;
  reg [7:0]  shift_reg;
  reg        ptr_phase_reg;
  reg [7:0]  ptr_reg;
  reg        drive_low_reg;
  reg        rd_dir_reg;
  reg [7:0]  protect_reg;
  reg [7:0]  tia_reg;
  reg [7:0]  ref_reg;
  reg [7:0]  mode_reg;
  reg        ready_reg;
  reg [31:0] ready_cnt_reg;
  reg [7:0]  rd_data;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire       scl_stuck;
  wire       sda_stuck;
  wire       bus_reset;

  // edges seen on synced copies only, so pin skew cannot fake a condition
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // idle low scl is harmless, so only transactions count
  // scl low watchdog
  afecp_timer #(
    .LIMIT (TIMEOUT_CYC),
    .WIDTH (32)
  ) u_scl_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_run     (~scl_s && state_reg != ST_IDLE),
    .o_expired (scl_stuck)
  );

  afecp_timer #(
    .LIMIT (TIMEOUT_CYC),
    .WIDTH (32)
  ) u_sda_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_run     (drive_low_reg),
    .o_expired (sda_stuck)
  );

  // either watchdog drops the state machine and frees sda
  assign bus_reset = scl_stuck | sda_stuck;

  // counter stops once ready is set
  // power-up ready
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ready_cnt_reg <= 32'h0;
      ready_reg     <= 1'b0;
    end else if (ready_cnt_reg >= READY_CYC - 1) begin
      ready_reg <= 1'b1;
    end else begin
      ready_cnt_reg <= ready_cnt_reg + 32'h1;
    end
  end

  // pointer decode for the read path
  // reserved reads as zero
  always @* begin
    case (ptr_reg)
      `AFECP_OFS_STATUS:  rd_data = {7'h00, ready_reg};
      `AFECP_OFS_PROTECT: rd_data = protect_reg;
      `AFECP_OFS_TIA:     rd_data = tia_reg;
      `AFECP_OFS_REF:     rd_data = ref_reg;
      `AFECP_OFS_MODE:    rd_data = mode_reg;
      default:            rd_data = 8'h00;
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
      state_reg     <= ST_IDLE;
      bit_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      ptr_phase_reg <= 1'b0;
      ptr_reg       <= 8'h00;
      drive_low_reg <= 1'b0;
      rd_dir_reg    <= 1'b0;
      protect_reg   <= `AFECP_RST_PROTECT;
      tia_reg       <= `AFECP_RST_TIA;
      ref_reg       <= `AFECP_RST_REF;
      mode_reg      <= `AFECP_RST_MODE;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (sel_n_s || bus_reset || stop_cond) begin
        state_reg     <= ST_IDLE;
        drive_low_reg <= 1'b0;
      end else if (start_cond) begin
        state_reg     <= ST_ADDR;
        bit_reg       <= 4'h0;
        drive_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_reg   <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin
              if (shift_reg[7:1] == `AFECP_TARGET_ADDR) begin
                drive_low_reg <= 1'b1;
                rd_dir_reg    <= shift_reg[0];
                state_reg     <= ST_AACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            // ack bit ends on this fall
            if (scl_fall) begin
              bit_reg <= 4'h0;
              if (rd_dir_reg) begin
                shift_reg     <= rd_data;
                drive_low_reg <= ~rd_data[7];
                state_reg     <= ST_TX;
              end else begin
                drive_low_reg <= 1'b0;
                ptr_phase_reg <= 1'b1;
                state_reg     <= ST_WRX;
              end
            end
          end
          ST_WRX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_reg   <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin
              drive_low_reg <= 1'b1;
              state_reg     <= ST_WACK;
              if (ptr_phase_reg) begin
                // pointer does not auto-increment
                ptr_reg <= shift_reg;
              end else begin
                case (ptr_reg)
                  `AFECP_OFS_PROTECT: protect_reg <= shift_reg & `AFECP_MASK_PROTECT;
                  `AFECP_OFS_TIA:
                    if (!protect_reg[`AFECP_PROTECT_BIT]) tia_reg <= shift_reg & `AFECP_MASK_TIA;
                  `AFECP_OFS_REF:
                    if (!protect_reg[`AFECP_PROTECT_BIT]) ref_reg <= shift_reg & `AFECP_MASK_REF;
                  `AFECP_OFS_MODE:    mode_reg <= shift_reg & `AFECP_MASK_MODE;
                  default:            mode_reg <= mode_reg;
                endcase
              end
            end
          end
          ST_WACK: begin
            // further bytes go to the same pointer
            if (scl_fall) begin
              drive_low_reg <= 1'b0;
              ptr_phase_reg <= 1'b0;
              bit_reg       <= 4'h0;
              state_reg     <= ST_WRX;
            end
          end
          ST_TX: begin
            // next bit set up while scl is low
            if (scl_fall) begin
              if (bit_reg == 4'h7) begin
                drive_low_reg <= 1'b0;
                state_reg     <= ST_RACK;
              end else begin
                shift_reg     <= {shift_reg[6:0], 1'b0};
                drive_low_reg <= ~shift_reg[6];
                bit_reg       <= bit_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // master ack repeats the byte, nack ends
            if (scl_rise) begin
              state_reg <= sda_s ? ST_IDLE : ST_AACK;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign o_sda      = 1'b0;
  assign o_sda_oe_n = ~drive_low_reg;

  assign o_feedback_resistor_sel = tia_reg[4:2];
  assign o_load_resistor_sel     = tia_reg[1:0];
  assign o_ref_source_ext        = ref_reg[7];
  assign o_internal_zero_sel     = ref_reg[6:5];
  assign o_bias_negative         = ref_reg[4];
  assign o_bias_sel              = ref_reg[3:0];
  assign o_shorting_switch_en    = mode_reg[7];
  assign o_operating_mode_sel    = mode_reg[2:0];
  assign o_ready                 = ready_reg;
endmodule // afecp_port

// *** afecp_port_properties.sv ***
module afecp_port_properties #(
  parameter TIMEOUT_CYC = 2000,
  parameter READY_CYC   = 20
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire o_sda,
  input wire o_sda_oe_n,
  input wire i_module_select_n,
  input wire o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] age_reg;
  logic [31:0] low_reg;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      age_reg <= 32'h0;
      low_reg <= 32'h0;
    end else begin
      age_reg <= age_reg + 32'h1;
      low_reg <= o_sda_oe_n ? 32'h0 : low_reg + 32'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_sda_pull_low: assert property (o_sda == 1'b0)
    else $error("sda data not low");
  a_drive_scl_low: assert property ($changed(o_sda_oe_n) && low_reg < TIMEOUT_CYC |-> !$past(i_scl, 2))
    else $error("sda changed with scl high");
  a_ready_not_early: assert property (age_reg < READY_CYC - 1 |-> !o_ready)
    else $error("ready too early");
  a_ready_in_time: assert property (age_reg > READY_CYC + 2 |-> o_ready)
    else $error("ready too late");
  a_reset_idle: assert property (disable iff (1'b0) i_rst |-> o_sda_oe_n && !o_ready)
    else $error("reset state wrong");
  a_deselect_silent: assert property (i_module_select_n [*4] |-> o_sda_oe_n)
    else $error("drive while deselected");
  a_ack_stands: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*6])
    else $error("drive too short");
  a_hold_bounded: assert property (low_reg <= TIMEOUT_CYC + 8)
    else $error("sda held past timeout");
  c_ack: cover property ($fell(o_sda_oe_n));
  c_ready: cover property ($rose(o_ready));
  c_timeout: cover property (low_reg == TIMEOUT_CYC);
endmodule // afecp_port_properties

bind afecp_port afecp_port_properties #(.TIMEOUT_CYC(TIMEOUT_CYC), .READY_CYC(READY_CYC)) afecp_port_properties_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
  .i_module_select_n(i_module_select_n), .o_ready(o_ready));

// *** afecp_master_model.sv ***
module afecp_master_model (
  input  wire  i_clk,
  input  wire  i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_oe_n = 1'b1,
  output logic o_module_select_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wait_clk(2);
    o_sda_oe_n <= b;
    wait_clk(2);
    o_scl <= 1'b1;
    wait_clk(3);
    @(negedge i_clk);
    r = i_sda;
    @(posedge i_clk);
    o_scl <= 1'b0;
  endtask
  // ack bit with scl parked high
  task automatic park_high(input int n);
    wait_clk(2);
    o_sda_oe_n <= 1'b1;
    wait_clk(2);
    o_scl <= 1'b1;
    wait_clk(n);
    o_scl <= 1'b0;
  endtask
  task automatic start(input logic sel_n);
    wait_clk(1);
    o_module_select_n <= sel_n;
    wait_clk(2);
    o_sda_oe_n <= 1'b0;
    wait_clk(4);
    o_scl <= 1'b0;
  endtask
  task automatic restart();
    wait_clk(4);
    o_sda_oe_n <= 1'b1;
    wait_clk(4);
    o_scl <= 1'b1;
    wait_clk(4);
    o_sda_oe_n <= 1'b0;
    wait_clk(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    wait_clk(2);
    o_sda_oe_n <= 1'b0;
    wait_clk(2);
    o_scl <= 1'b1;
    wait_clk(4);
    o_sda_oe_n <= 1'b1;
    wait_clk(4);
    o_module_select_n <= 1'b1;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic [2:0] a);
    start(1'b0);
    send_byte(8'h90, a[2]);
    send_byte(p, a[1]);
    send_byte(d, a[0]);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic [2:0] a);
    start(1'b0);
    send_byte(8'h90, a[2]);
    send_byte(p, a[1]);
    restart();
    send_byte(8'h91, a[0]);
    recv_byte(1'b1, d);
    stop();
  endtask
endmodule // afecp_master_model

// *** afecp_port_test.sv ***
module afecp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 2000;
  localparam int RDY = 20;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b0;
  wire        scl;
  wire        m_oe_n;
  wire        sel_n;
  wire        d_sda;
  wire        d_oe_n;
  wire        sda = m_oe_n & (d_oe_n | d_sda);
  wire  [2:0] fb;
  wire  [1:0] ld;
  wire        rs;
  wire  [1:0] iz;
  wire        bn;
  wire  [3:0] bs;
  wire        sh;
  wire  [2:0] md;
  wire        rdy;
  int         num_errors = 0;
  int         cmp_count = 0;
  always #20 i_clk = ~i_clk;
  afecp_port #(.TIMEOUT_CYC(TMO), .READY_CYC(RDY)) afecp_port_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(d_sda), .o_sda_oe_n(d_oe_n),
    .i_module_select_n(sel_n), .o_feedback_resistor_sel(fb), .o_load_resistor_sel(ld),
    .o_ref_source_ext(rs), .o_internal_zero_sel(iz), .o_bias_negative(bn), .o_bias_sel(bs),
    .o_shorting_switch_en(sh), .o_operating_mode_sel(md), .o_ready(rdy));
  afecp_master_model afecp_master_model_inst (
    .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n), .o_module_select_n(sel_n));
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    @(negedge i_clk);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [2:0] a;
    afecp_master_model_inst.write_reg(p, d, a);
    check("write acks", 8'h07, {5'h0, a});
  endtask
  task automatic rd(input string n, input logic [7:0] p, input logic [7:0] e);
    logic [2:0] a;
    logic [7:0] d;
    afecp_master_model_inst.read_reg(p, d, a);
    check("read acks", 8'h07, {5'h0, a});
    check(n, e, d);
  endtask
  task automatic t_lock();
    wr(8'h10, 8'h0A);
    rd("locked tia", 8'h10, 8'h1C);
    wr(8'h01, 8'h00);
    wr(8'h10, 8'h0A);
    check("tia out", 8'h0A, {3'h0, fb, ld});
    wr(8'h11, 8'hFD);
    check("ref out", 8'hFD, {rs, iz, bn, bs});
    wr(8'h01, 8'h01);
    wr(8'h11, 8'h00);
    rd("relocked ref", 8'h11, 8'hFD);
  endtask
  task automatic t_mode();
    logic [2:0] c [6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0};
    foreach (c[i]) begin
      wr(8'h12, {i[0], 4'h0, c[i]});
      check("mode", {i[0], 4'h0, c[i]}, {sh, 4'h0, md});
    end
    wr(8'h05, 8'hAA);
    rd("reserved", 8'h05, 8'h00);
  endtask
  task automatic t_refuse();
    logic a;
    afecp_master_model_inst.start(1'b0);
    afecp_master_model_inst.send_byte(8'h92, a);
    afecp_master_model_inst.stop();
    check("wrong addr ack", 8'h00, {7'h0, a});
    afecp_master_model_inst.start(1'b1);
    afecp_master_model_inst.send_byte(8'h90, a);
    afecp_master_model_inst.stop();
    check("deselected ack", 8'h00, {7'h0, a});
  endtask
  task automatic t_stall();
    logic r;
    afecp_master_model_inst.start(1'b0);
    for (int i = 7; i >= 4; i--) afecp_master_model_inst.bit_io(i == 7 || i == 4, r);
    afecp_master_model_inst.wait_clk(TMO + 8);
    for (int i = 3; i >= 0; i--) afecp_master_model_inst.bit_io(1'b0, r);
    afecp_master_model_inst.bit_io(1'b1, r);
    check("stuck scl ack", 8'h01, {7'h0, r});
    afecp_master_model_inst.stop();
    afecp_master_model_inst.start(1'b0);
    for (int i = 7; i >= 0; i--) afecp_master_model_inst.bit_io(i == 7 || i == 4, r);
    afecp_master_model_inst.wait_clk(8);
    check("ack held", 8'h00, {7'h0, d_oe_n});
    afecp_master_model_inst.wait_clk(TMO);
    check("sda freed", 8'h01, {7'h0, d_oe_n});
    afecp_master_model_inst.stop();
    afecp_master_model_inst.start(1'b0);
    for (int i = 7; i >= 0; i--) afecp_master_model_inst.bit_io(i == 7 || i == 4, r);
    afecp_master_model_inst.park_high(TMO + 8);
    check("sda freed scl high", 8'h01, {7'h0, d_oe_n});
    afecp_master_model_inst.stop();
    rd("status after stall", 8'h00, 8'h01);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
  initial begin
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check("ready early", 8'h00, {7'h0, rdy});
    repeat (RDY + 4) @(posedge i_clk);
    check("ready", 8'h01, {7'h0, rdy});
    check("gain reset", 8'h07, {5'h0, fb});
    rd("status", 8'h00, 8'h01);
    rd("protect", 8'h01, 8'h01);
    rd("tia", 8'h10, 8'h1C);
    rd("mode", 8'h12, 8'h00);
    t_lock();
    t_mode();
    t_refuse();
    t_stall();
    end_sim();
  end
endmodule // afecp_port_test
